/* File: rtl/lasm_alarm_ctrl.sv */
// Behaviour
// - A read-only 8-bit flag register at 01h maps bits 0-6 to inputs 0-6 and bit 7 to temperature in mode 0, and bits 0-7 to inputs 0-7 in mode 1.
// - A voltage channel's flag sets when its reading passes its upper or lower limit.
// - The temperature flag sets only on passing the upper limit.
// - In mode 2 bits 0-3 flag pairs 0/1, 3/2, 4/5, 7/6, bits 4-6 are reserved, bit 7 is temperature.
// - In mode 3 bits 0-3 flag inputs 0-3, bit 4 pair 4/5, bit 5 pair 7/6, bit 6 reserved, bit 7 temperature.
// - A read/write 8-bit gate register at 03h mirrors the flag layout, reserved bits read-only.
// - A gate bit of 1 keeps its flag off the alarm pin while the flag still records.
// - In mode 2 gate bits 0-3 gate the four pairs and gate bit 7 gates temperature.
// - The alarm pin is driven only while the alarm enable bit is 1.
// - The release bit releases the alarm pin without touching the flags and halts the monitoring loop.
// - A disabled channel never raises its flag and reads as zero.
`include "lasm_cfg.svh"
`default_nettype none
module lasm_alarm_ctrl #(
  parameter int NUM_CH = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  input  wire logic              init_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic [1:0]        mode_i,
  input  wire logic [NUM_CH-1:0] chan_disable_i,
  input  wire logic [NUM_CH-1:0] limit_hi_i,
  input  wire logic [NUM_CH-1:0] limit_lo_i,
  input  wire logic              alarm_enable_i,
  input  wire logic              alarm_release_i,
  output logic                   monitor_halt_o,
  output logic                   alarm_n_o,
  output logic                   alarm_oe_n_o
);

  // the bit layouts and reset values are eight bits wide
  if (NUM_CH != 8) begin : g_num_ch_check
    $error("lasm_alarm_ctrl serves exactly eight channels");
  end

  logic [NUM_CH-1:0]    flags_ff;
  logic [NUM_CH-1:0]    gate_ff;
  logic [NUM_CH-1:0]    valid;
  logic [NUM_CH-1:0]    hit;
  logic                 pending;
  logic                 flags_rd;
  lasm_pkg::lasm_alarm_e alm_ff;
  lasm_pkg::lasm_alarm_e nxt_alm;

  lasm_event_qual #(
    .NUM_CH (NUM_CH)
  ) u_qual (
    .mode_i         (mode_i),
    .limit_hi_i     (limit_hi_i),
    .limit_lo_i     (limit_lo_i),
    .chan_disable_i (chan_disable_i),
    .valid_o        (valid),
    .hit_o          (hit)
  );

  assign flags_rd = reg_rd_i && (reg_addr_i == `LASM_OFS_FLAGS);

  // sticky flags, cleared by reading them; a new hit wins over the read clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= `LASM_RST_FLAGS;
    end else if (clk_en_i) begin
      if (init_i) begin
        flags_ff <= `LASM_RST_FLAGS;
      end else begin
        flags_ff <= ((flags_rd ? '0 : flags_ff) | hit) & valid & ~chan_disable_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_ff <= `LASM_RST_GATE;
    end else if (clk_en_i) begin
      if (init_i) begin
        gate_ff <= `LASM_RST_GATE;
      end else if (reg_wr_i && reg_addr_i == `LASM_OFS_GATE) begin
        gate_ff <= reg_wdata_i & valid;
      end
    end
  end

  // read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `LASM_RST_RDATA;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        `LASM_OFS_FLAGS: reg_rdata_o <= flags_ff & valid;
        `LASM_OFS_GATE:  reg_rdata_o <= gate_ff & valid;
        default:         reg_rdata_o <= `LASM_RST_RDATA;
      endcase
    end
  end

  assign pending = |(flags_ff & ~gate_ff & valid);

  always_comb begin
    case (alm_ff)
      lasm_pkg::LASM_ALM_IDLE: begin
        if (alarm_release_i) begin
          nxt_alm = lasm_pkg::LASM_ALM_HELD;
        end else if (alarm_enable_i && pending) begin
          nxt_alm = lasm_pkg::LASM_ALM_ACTIVE;
        end else begin
          nxt_alm = lasm_pkg::LASM_ALM_IDLE;
        end
      end
      lasm_pkg::LASM_ALM_ACTIVE: begin
        if (alarm_release_i) begin
          nxt_alm = lasm_pkg::LASM_ALM_HELD;
        end else if (!alarm_enable_i || !pending) begin
          nxt_alm = lasm_pkg::LASM_ALM_IDLE;
        end else begin
          nxt_alm = lasm_pkg::LASM_ALM_ACTIVE;
        end
      end
      lasm_pkg::LASM_ALM_HELD: begin
        nxt_alm = alarm_release_i ? lasm_pkg::LASM_ALM_HELD : lasm_pkg::LASM_ALM_IDLE;
      end
      default: nxt_alm = lasm_pkg::LASM_ALM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alm_ff <= lasm_pkg::LASM_ALM_IDLE;
    end else if (clk_en_i) begin
      alm_ff <= init_i ? lasm_pkg::LASM_ALM_IDLE : nxt_alm;
    end
  end

  // pin value, registered from the next state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_n_o <= 1'b1;
    end else if (clk_en_i) begin
      alarm_n_o <= init_i || (nxt_alm != lasm_pkg::LASM_ALM_ACTIVE);
    end
  end

  // open-drain enable, low only while the pin is pulled low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      alarm_oe_n_o <= init_i || (nxt_alm != lasm_pkg::LASM_ALM_ACTIVE);
    end
  end

  // loop halt while the release bit holds
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_halt_o <= 1'b0;
    end else if (clk_en_i) begin
      monitor_halt_o <= !init_i && (nxt_alm == lasm_pkg::LASM_ALM_HELD);
    end
  end

endmodule : lasm_alarm_ctrl
`default_nettype wire

/* File: rtl/lasm_cfg.svh */
`ifndef LASM_CFG_SVH
`define LASM_CFG_SVH

// register offsets
`define LASM_OFS_FLAGS     8'h01
`define LASM_OFS_GATE      8'h03
// reset values
`define LASM_RST_FLAGS     8'h00
`define LASM_RST_GATE      8'h00
`define LASM_RST_RDATA     8'h00
// field positions
`define LASM_TEMP_BIT      7
// implemented bits of flag and gate per mode
`define LASM_VALID_MODE0   8'hFF
`define LASM_VALID_MODE1   8'hFF
`define LASM_VALID_MODE2   8'h8F
`define LASM_VALID_MODE3   8'hBF
// mode codes
`define LASM_MODE0         2'h0
`define LASM_MODE1         2'h1
`define LASM_MODE2         2'h2
`define LASM_MODE3         2'h3

`endif

/* File: rtl/lasm_pkg.sv */
`default_nettype none
package lasm_pkg;

  typedef enum logic [1:0] {
    LASM_MODE_SINGLE = 2'h0,
    LASM_MODE_SE_ALL = 2'h1,
    LASM_MODE_PAIRS  = 2'h2,
    LASM_MODE_MIXED  = 2'h3
  } lasm_mode_e;

  typedef enum logic [2:0] {
    LASM_ALM_IDLE   = 3'h1,
    LASM_ALM_ACTIVE = 3'h2,
    LASM_ALM_HELD   = 3'h4
  } lasm_alarm_e;

endpackage : lasm_pkg
`default_nettype wire

/* File: rtl/lasm_event_qual.sv */
`include "lasm_cfg.svh"
`default_nettype none
module lasm_event_qual #(
  parameter int NUM_CH = 8
) (
  input  wire logic [1:0]        mode_i,
  input  wire logic [NUM_CH-1:0] limit_hi_i,
  input  wire logic [NUM_CH-1:0] limit_lo_i,
  input  wire logic [NUM_CH-1:0] chan_disable_i,
  output logic      [NUM_CH-1:0] valid_o,
  output logic      [NUM_CH-1:0] hit_o
);

  logic [NUM_CH-1:0] lo_ok;

  always_comb begin
    case (mode_i)
      `LASM_MODE0: valid_o = `LASM_VALID_MODE0;
      `LASM_MODE1: valid_o = `LASM_VALID_MODE1;
      `LASM_MODE2: valid_o = `LASM_VALID_MODE2;
      `LASM_MODE3: valid_o = `LASM_VALID_MODE3;
      default:     valid_o = `LASM_VALID_MODE0;
    endcase
  end

  always_comb begin
    lo_ok = limit_lo_i;
    // temperature has no lower alarm except in mode 1 where bit 7 is a voltage input
    if (mode_i != `LASM_MODE1) begin
      lo_ok[`LASM_TEMP_BIT] = 1'b0;
    end
  end

  assign hit_o = (limit_hi_i | lo_ok) & valid_o & ~chan_disable_i;

endmodule : lasm_event_qual
`default_nettype wire

/* File: bench/lasm_alarm_ctrl_props.sv */
`default_nettype none
module lasm_alarm_ctrl_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       clk_en_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] mode_i,
  input wire logic       alarm_enable_i,
  input wire logic       alarm_release_i,
  input wire logic       monitor_halt_o,
  input wire logic       alarm_n_o,
  input wire logic       alarm_oe_n_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic rd_ok;
  assign rd_ok = reg_rd_i && clk_en_i;
  a_oe_tracks_pin: assert property (alarm_oe_n_o == alarm_n_o)
    else $error("pin enable differs from pin");
  a_enable_off_quiet: assert property (!alarm_enable_i [*3] |-> alarm_n_o)
    else $error("alarm driven while disabled");
  a_release_halts_loop: assert property (alarm_release_i [*3] |=> monitor_halt_o && alarm_n_o)
    else $error("release not honoured");
  a_halt_quiet_idle: assert property (!alarm_release_i [*3] |=> !monitor_halt_o)
    else $error("halt without release");
  a_halt_pin_high: assert property (monitor_halt_o |-> alarm_n_o)
    else $error("alarm low while halted");
  a_unmapped_reads_zero: assert property (rd_ok && reg_addr_i != 8'h01 && reg_addr_i != 8'h03
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_ok |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_mode2_reserved: assert property (rd_ok && reg_addr_i == 8'h01 && mode_i == 2'h2
    |=> reg_rdata_o[6:4] == 3'h0) else $error("reserved flag set in mode 2");
  a_mode3_reserved: assert property (rd_ok && reg_addr_i == 8'h01 && mode_i == 2'h3
    |=> !reg_rdata_o[6]) else $error("reserved flag set in mode 3");
endmodule : lasm_alarm_ctrl_props
bind lasm_alarm_ctrl lasm_alarm_ctrl_props u_props (.clk_sys_i, .rst_n_i, .clk_en_i, .reg_rd_i, .reg_addr_i,
  .reg_rdata_o, .mode_i, .alarm_enable_i, .alarm_release_i, .monitor_halt_o, .alarm_n_o, .alarm_oe_n_o);
`default_nettype wire

/* File: bench/lasm_host.sv */
`default_nettype none
module lasm_host (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i) {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_sys_i) {wr_o, wdata_o} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i) {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_sys_i) rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : lasm_host
`default_nettype wire

/* File: bench/lasm_alarm_ctrl_tb.sv */
`default_nettype none
module lasm_alarm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i = 0, rst_n_i = 0, en = 0, rel = 0, ce = 1, ini = 0, wr, rd, halt, aln, oe;
  logic [1:0] mode = 0;
  logic [7:0] dis = 0, hi = 0, lo = 0, addr, wd, rdata, v;
  logic [7:0] lo_exp [4] = '{8'h7F, 8'hFF, 8'h0F, 8'h3F};
  logic [7:0] hi_exp [4] = '{8'hFF, 8'hFF, 8'h8F, 8'hBF};
  int         err_count = 0, check_count = 0, cyc = 0;
  lasm_host host (.clk_sys_i, .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  lasm_alarm_ctrl dut (.clk_sys_i, .rst_n_i, .clk_en_i(ce), .init_i(ini), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .mode_i(mode), .chan_disable_i(dis), .limit_hi_i(hi),
    .limit_lo_i(lo), .alarm_enable_i(en), .alarm_release_i(rel), .monitor_halt_o(halt), .alarm_n_o(aln),
    .alarm_oe_n_o(oe));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic ev(input logic [7:0] h, input logic [7:0] l);
    @(negedge clk_sys_i) {hi, lo} = {h, l};
    @(negedge clk_sys_i) {hi, lo} = '0;
    repeat (2) @(negedge clk_sys_i);
  endtask : ev
  task automatic rf(input logic [7:0] exp);
    host.rd(8'h01, v);
    chk(v, exp, "flags");
  endtask : rf
  task automatic ca(input logic exp);
    chk({6'h0, oe, aln}, {6'h0, exp, exp}, "alarm");
  endtask : ca
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1;
    rf(8'h00);
    host.rd(8'h03, v);
    chk(v, 8'h00, "gate");
    en = 1;
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      ev(8'h00, 8'hFF);
      ca(1'b0);
      rf(lo_exp[m]);
      ev(8'hFF, 8'h00);
      rf(hi_exp[m]);
    end
    rf(8'h00);
    repeat (2) @(negedge clk_sys_i);
    ca(1'b1);
    host.wr(8'h01, 8'hFF);
    rf(8'h00);
    mode = 2'h2;
    host.wr(8'h03, 8'hFF);
    host.rd(8'h03, v);
    chk(v, 8'h8F, "gate");
    host.wr(8'h03, 8'h0F);
    ev(8'h08, 8'h00);
    ca(1'b1);
    rf(8'h08);
    ev(8'h80, 8'h00);
    ca(1'b0);
    rf(8'h80);
    host.wr(8'h03, 8'h00);
    mode = 2'h0;
    dis = 8'h04;
    ev(8'h04, 8'h00);
    rf(8'h00);
    dis = 8'h00;
    en = 0;
    ev(8'h04, 8'h00);
    ca(1'b1);
    en = 1;
    repeat (3) @(negedge clk_sys_i);
    ca(1'b0);
    rel = 1;
    repeat (4) @(negedge clk_sys_i);
    ca(1'b1);
    chk({7'h0, halt}, 8'h01, "halt");
    rf(8'h04);
    rel = 0;
    repeat (4) @(negedge clk_sys_i);
    chk({7'h0, halt}, 8'h00, "halt");
    ce = 0;
    ev(8'h02, 8'h00);
    ce = 1;
    rf(8'h00);
    host.wr(8'h03, 8'h01);
    ev(8'h01, 8'h00);
    ca(1'b1);
    ini = 1;
    @(negedge clk_sys_i) ini = 0;
    rf(8'h00);
    host.rd(8'h03, v);
    chk(v, 8'h00, "gate");
    host.rd(8'h05, v);
    chk(v, 8'h00, "unmapped");
    end_sim();
  end
endmodule : lasm_alarm_ctrl_tb
`default_nettype wire
